// ### verilog/scc_top.sv
// System clock source controller with Wishbone register access.
//
// Operation
// - Slow source bit writable only in fast mode.
// - Fast source bit writable only in slow mode.
// - Fast crystal: high gain, claim crystal pins.
// - Slow stop bit halts slow clock in stop.
// - Peripheral gate bit stops timer clocks in idle.
// - Fast stop bit, writable only in slow mode.
// - System source bit, writable only fast running.
// - Divider field 00/01/10/11 gives 16/4/2/1.
// - New ratio applies within sixteen source cycles.
// - Detector enables and detector one sensitivity.
// - Force slow clock while transient detected.
// - Hold processor waiting while transient detected.
`timescale 1ns/1ps
`default_nettype none
module scc_top
  import scc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Oscillator clock pins, sampled as tick sources.
  input  wire logic        slow_rc_osc_in,
  input  wire logic        slow_crystal_in,
  input  wire logic        fast_rc_osc_in,
  input  wire logic        fast_crystal_in,
  // Transient detector pins.
  input  wire logic        transient_detector1_in,
  input  wire logic        transient_detector2_in,
  // Power modes from the processor core.
  input  wire logic        stop_mode_in,
  input  wire logic        idle_mode_in,
  // Oscillator and pad control.
  output logic             slow_osc_enable_out,
  output logic             fast_osc_enable_out,
  output logic             slow_crystal_select_out,
  output logic             fast_crystal_select_out,
  output logic             crystal_high_gain_out,
  output logic             crystal_pins_claim_out,
  // Detector control.
  output logic             transient_detector1_enable_out,
  output logic             transient_detector2_enable_out,
  output logic [1:0]       transient_detector1_sensitivity_out,
  output logic             transient_cpu_wait_out,
  // System and peripheral clock enables.
  output logic             system_tick_out,
  output logic             peripheral_tick_out
);

  // Register state.
  logic [7:0] clock_control_reg;   // Clock control register.
  logic [7:0] transient_reg;       // Transient detector control register.

  // Named views of the clock control fields.
  logic       slow_source_select;      // Slow source: rc or crystal.
  logic       fast_source_select;      // Fast source: rc or crystal.
  logic       slow_osc_stop_in_stop;   // Halt slow oscillator in stop.
  logic       peripheral_gate_in_idle; // Gate peripherals in idle.
  logic       fast_osc_stop;           // Stop the fast oscillator.
  logic       system_source_select;    // Requested system source.
  logic [1:0] system_divider;          // Prescaler code.

  // Named views of the transient fields.
  logic       transient_force_slow;    // Force slow clock on transient.
  logic       transient_cpu_wait;      // Stall processor on transient.

  // Pin synchronisers and edge detection.
  logic [SCC_PIN_COUNT-1:0] pin_meta_reg;   // First synchroniser stage.
  logic [SCC_PIN_COUNT-1:0] pin_sync_reg;   // Second synchroniser stage.
  logic [SCC_PIN_COUNT-1:0] pin_prev_reg;   // Delayed copy for edges.
  logic [SCC_PIN_COUNT-1:0] pin_rise;       // Rising edge of each pin.

  // Clock path.
  logic       transient_active;   // Any enabled detector is firing.
  logic       want_fast;          // Source that software and detectors ask for.
  logic       fast_active_reg;    // Source that the divider is counting now.
  logic       slow_tick;          // Tick of the chosen slow source.
  logic       fast_tick;          // Tick of the chosen fast source.
  logic       src_tick;           // Tick of the active source.
  logic       div_tick;           // Output tick of the prescaler.
  logic       switch_now;         // Source change taken at a period edge.

  // Bus decode.
  logic                       bus_req;     // A new request awaits an answer.
  logic                       bus_write;   // A new write to the low byte lane.
  logic [SCC_INDEX_WIDTH-1:0] bus_index;   // Word index of the request.
  logic [7:0]                 wr_byte;     // Written byte.
  logic [7:0]                 cc_next;     // Clock control after a write.
  logic [7:0]                 status_byte; // Live status view.

  assign slow_source_select      = clock_control_reg[SCC_SLOW_SOURCE_BIT];
  assign fast_source_select      = clock_control_reg[SCC_FAST_SOURCE_BIT];
  assign slow_osc_stop_in_stop   = clock_control_reg[SCC_SLOW_STOP_BIT];
  assign peripheral_gate_in_idle = clock_control_reg[SCC_PERIPH_GATE_BIT];
  assign fast_osc_stop           = clock_control_reg[SCC_FAST_STOP_BIT];
  assign system_source_select    = clock_control_reg[SCC_SYSTEM_SOURCE_BIT];
  assign system_divider          = clock_control_reg[SCC_DIVIDER_MSB:SCC_DIVIDER_LSB];
  assign transient_force_slow    = transient_reg[SCC_FORCE_SLOW_BIT];
  assign transient_cpu_wait      = transient_reg[SCC_CPU_WAIT_BIT];

  // Every pin passes two flip-flops before logic reads it; the third stage
  // only serves edge detection on the settled value.
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < SCC_PIN_COUNT; pin_idx++) begin : g_pin_sync
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          pin_meta_reg[pin_idx] <= 1'b0;
          pin_sync_reg[pin_idx] <= 1'b0;
          pin_prev_reg[pin_idx] <= 1'b0;
        end else begin
          pin_meta_reg[pin_idx] <= (pin_idx == 0) ? slow_rc_osc_in :
                                   (pin_idx == 1) ? slow_crystal_in :
                                   (pin_idx == 2) ? fast_rc_osc_in :
                                   (pin_idx == 3) ? fast_crystal_in :
                                   (pin_idx == 4) ? transient_detector1_in :
                                                    transient_detector2_in;
          pin_sync_reg[pin_idx] <= pin_meta_reg[pin_idx];
          pin_prev_reg[pin_idx] <= pin_sync_reg[pin_idx];
        end
      end
      assign pin_rise[pin_idx] = pin_sync_reg[pin_idx] & ~pin_prev_reg[pin_idx];
    end
  endgenerate

  // A transient counts only from a detector that software has enabled.
  assign transient_active =
    (transient_reg[SCC_DET1_ENABLE_BIT] & pin_sync_reg[4]) |
    (transient_reg[SCC_DET2_ENABLE_BIT] & pin_sync_reg[5]);

  // The forced slow request overrides the software choice.
  assign want_fast = system_source_select &
                     ~(transient_force_slow & transient_active);

  // Pick the crystal or rc tick of each class.
  assign slow_tick = slow_source_select ? pin_rise[1] : pin_rise[0];
  assign fast_tick = fast_source_select ? pin_rise[3] : pin_rise[2];
  assign src_tick  = fast_active_reg ? fast_tick : slow_tick;

  // A source change waits for the end of a system period, so the output
  // never carries a fragment of either source's period.
  // A stopped old oscillator never ends its period, so its disable
  // lets the change through at once.
  assign switch_now = (want_fast != fast_active_reg) &
                      (div_tick | ~(fast_active_reg ? fast_osc_enable_out
                                                    : slow_osc_enable_out));

  // Tracks which source the prescaler is counting.
  // Status reads this flop, not the register bit, so software can see
  // when a requested change has really been made.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      fast_active_reg <= 1'b0;
    end else if (switch_now) begin
      fast_active_reg <= want_fast;
    end
  end

  // Prescaler on the active source; restarted when the source changes.
  scc_clk_divider u_divider (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .src_tick_in   (src_tick),
    .ratio_code_in (system_divider),
    .restart_in    (switch_now),
    .tick_out      (div_tick)
  );

  // System and peripheral tick enables, registered for clean outputs.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      system_tick_out     <= 1'b0;
      peripheral_tick_out <= 1'b0;
    end else begin
      system_tick_out     <= div_tick;
      // Peripheral clocks stop in idle when the gate bit is set.
      peripheral_tick_out <= div_tick &
                             ~(idle_mode_in & peripheral_gate_in_idle);
    end
  end

  // Oscillator, pad and detector controls.
  // Each control is a flop, so pads never see decode glitches.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      slow_osc_enable_out                 <= 1'b1;
      fast_osc_enable_out                 <= 1'b1;
      slow_crystal_select_out             <= 1'b0;
      fast_crystal_select_out             <= 1'b0;
      crystal_high_gain_out               <= 1'b0;
      crystal_pins_claim_out              <= 1'b0;
      transient_detector1_enable_out      <= 1'b0;
      transient_detector2_enable_out      <= 1'b0;
      transient_detector1_sensitivity_out <= 2'h0;
      transient_cpu_wait_out              <= 1'b0;
    end else begin
      slow_osc_enable_out     <= ~(stop_mode_in & slow_osc_stop_in_stop);
      fast_osc_enable_out     <= ~fast_osc_stop;
      slow_crystal_select_out <= slow_source_select;
      fast_crystal_select_out <= fast_source_select;
      crystal_high_gain_out   <= fast_source_select;
      crystal_pins_claim_out  <= fast_source_select | slow_source_select;
      transient_detector1_enable_out <= transient_reg[SCC_DET1_ENABLE_BIT];
      transient_detector2_enable_out <= transient_reg[SCC_DET2_ENABLE_BIT];
      transient_detector1_sensitivity_out <=
        transient_reg[SCC_DET1_SENS_MSB:SCC_DET1_SENS_LSB];
      transient_cpu_wait_out  <= transient_cpu_wait & transient_active;
    end
  end

  // Bus request decode: a request is new while ack has not been given.
  // Masking with ack keeps a held strobe from being taken twice, so
  // each request is answered once if the master drops it in the cycle after ack.
  assign bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign bus_write = bus_req & wb_we_in & wb_sel_in[0];
  assign bus_index = wb_adr_in[11:2];
  assign wr_byte   = wb_dat_in[7:0];

  // Guarded write of the clock control register; each protected bit keeps
  // its value unless the system is in the mode that allows the change.
  // The guards use the value before this write, so one write can never
  // unlock a protected bit and change it in the same cycle.
  always_comb begin
    cc_next = clock_control_reg;
    if (system_source_select) begin
      cc_next[SCC_SLOW_SOURCE_BIT] = wr_byte[SCC_SLOW_SOURCE_BIT];
    end
    if (!system_source_select) begin
      cc_next[SCC_FAST_SOURCE_BIT] = wr_byte[SCC_FAST_SOURCE_BIT];
      cc_next[SCC_FAST_STOP_BIT]   = wr_byte[SCC_FAST_STOP_BIT];
    end
    if (!fast_osc_stop) begin
      cc_next[SCC_SYSTEM_SOURCE_BIT] = wr_byte[SCC_SYSTEM_SOURCE_BIT];
    end
    cc_next[SCC_SLOW_STOP_BIT]   = wr_byte[SCC_SLOW_STOP_BIT];
    cc_next[SCC_PERIPH_GATE_BIT] = wr_byte[SCC_PERIPH_GATE_BIT];
    cc_next[SCC_DIVIDER_MSB:SCC_DIVIDER_LSB] =
      wr_byte[SCC_DIVIDER_MSB:SCC_DIVIDER_LSB];
  end

  // Clock control register.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      clock_control_reg <= SCC_CLOCK_CONTROL_RESET;
    end else if (bus_write && bus_index == SCC_CLOCK_CONTROL_INDEX) begin
      clock_control_reg <= cc_next;
    end
  end

  // Transient detector control register; the low two bits stay zero.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      transient_reg <= SCC_TRANSIENT_RESET;
    end else if (bus_write && bus_index == SCC_TRANSIENT_INDEX) begin
      transient_reg <= wr_byte & SCC_TRANSIENT_WR_MASK;
    end
  end

  // Live status of the clock path.
  // The upper bits read zero and the view has no write path.
  always_comb begin
    status_byte = 8'h00;
    status_byte[SCC_STAT_FAST_ACTIVE_BIT] = fast_active_reg;
    status_byte[SCC_STAT_TRANSIENT_BIT]   = transient_active;
    status_byte[SCC_STAT_FORCED_BIT]      = transient_force_slow & transient_active;
  end

  // Acknowledge one cycle after the request and drop it the cycle after;
  // unmapped indexes read zero and ignore writes.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req) begin
        if (bus_index == SCC_CLOCK_CONTROL_INDEX) begin
          wb_dat_out <= {24'h000000, clock_control_reg};
        end else if (bus_index == SCC_TRANSIENT_INDEX) begin
          wb_dat_out <= {24'h000000, transient_reg};
        end else if (bus_index == SCC_STATUS_INDEX) begin
          wb_dat_out <= {24'h000000, status_byte};
        end else begin
          wb_dat_out <= 32'h0000_0000;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### common/scc_pkg.sv
// Shared constants and helpers for the system clock source controller.
package scc_pkg;

  // Word index width of the Wishbone address (byte address bits 11..2).
  localparam int SCC_INDEX_WIDTH = 10;

  // Register indexes; the byte address is four times the index.
  localparam logic [SCC_INDEX_WIDTH-1:0] SCC_CLOCK_CONTROL_INDEX = 10'h0d8;
  localparam logic [SCC_INDEX_WIDTH-1:0] SCC_TRANSIENT_INDEX     = 10'h0e5;
  localparam logic [SCC_INDEX_WIDTH-1:0] SCC_STATUS_INDEX        = 10'h040;

  // Clock control field positions.
  localparam int SCC_SLOW_SOURCE_BIT   = 7;
  localparam int SCC_FAST_SOURCE_BIT   = 6;
  localparam int SCC_SLOW_STOP_BIT     = 5;
  localparam int SCC_PERIPH_GATE_BIT   = 4;
  localparam int SCC_FAST_STOP_BIT     = 3;
  localparam int SCC_SYSTEM_SOURCE_BIT = 2;
  localparam int SCC_DIVIDER_MSB       = 1;
  localparam int SCC_DIVIDER_LSB       = 0;

  // Transient detector control field positions.
  localparam int SCC_DET2_ENABLE_BIT   = 7;
  localparam int SCC_DET1_ENABLE_BIT   = 6;
  localparam int SCC_DET1_SENS_MSB     = 5;
  localparam int SCC_DET1_SENS_LSB     = 4;
  localparam int SCC_FORCE_SLOW_BIT    = 3;
  localparam int SCC_CPU_WAIT_BIT      = 2;

  // Status field positions.
  localparam int SCC_STAT_FAST_ACTIVE_BIT = 0;
  localparam int SCC_STAT_TRANSIENT_BIT   = 1;
  localparam int SCC_STAT_FORCED_BIT      = 2;

  // Reset values.
  localparam logic [7:0] SCC_CLOCK_CONTROL_RESET = 8'h23;
  localparam logic [7:0] SCC_TRANSIENT_RESET     = 8'h00;
  localparam logic [7:0] SCC_TRANSIENT_WR_MASK   = 8'hfc;

  // Divider codes.
  localparam logic [1:0] SCC_DIV16_CODE = 2'h0;
  localparam logic [1:0] SCC_DIV4_CODE  = 2'h1;
  localparam logic [1:0] SCC_DIV2_CODE  = 2'h2;
  localparam logic [1:0] SCC_DIV1_CODE  = 2'h3;

  // Longest delay, in source clock cycles, before a new ratio applies.
  localparam int SCC_RATIO_SETTLE_CYCLES = 16;

  // Number of asynchronous pin inputs that are synchronised.
  localparam int SCC_PIN_COUNT = 6;

  // Returns the last count value of one output period for a divider code.
  function automatic logic [3:0] scc_div_last(input logic [1:0] code);
    logic [3:0] last;
    last = 4'h0;
    unique case (code)
      SCC_DIV16_CODE: last = 4'hf;
      SCC_DIV4_CODE:  last = 4'h3;
      SCC_DIV2_CODE:  last = 4'h1;
      SCC_DIV1_CODE:  last = 4'h0;
    endcase
    return last;
  endfunction

endpackage

// ### verilog/scc_clk_divider.sv
// Prescaler that turns source clock ticks into system clock ticks.
`timescale 1ns/1ps
`default_nettype none
module scc_clk_divider
  import scc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // Source tick and ratio.
  input  wire logic       src_tick_in,
  input  wire logic [1:0] ratio_code_in,
  input  wire logic       restart_in,
  // Output tick.
  output logic            tick_out
);

  logic [3:0] count_reg;  // Source ticks seen in the current period.
  logic [3:0] last_reg;   // Terminal count of the period now running.

  // The ratio is reloaded only at the end of a full period or on a restart, which
  // also clears the count, so no short output period is ever produced; the longest wait is one 16-tick period.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      count_reg <= 4'h0;
      last_reg  <= scc_div_last(SCC_DIV1_CODE);
      tick_out  <= 1'b0;
    end else if (restart_in) begin
      count_reg <= 4'h0;
      last_reg  <= scc_div_last(ratio_code_in);
      tick_out  <= 1'b0;
    end else if (src_tick_in) begin
      if (count_reg == last_reg) begin
        count_reg <= 4'h0;
        last_reg  <= scc_div_last(ratio_code_in);
        tick_out  <= 1'b1;
      end else begin
        count_reg <= count_reg + 4'h1;
        tick_out  <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### test/scc_osc_model.sv
// Behavioural model of the four oscillators that feed the controller.
`timescale 1ns/1ps
`default_nettype none
module scc_osc_model (
  // Clock and oscillator enables from the controller.
  input  wire logic clock_in,
  input  wire logic slow_enable_in,
  input  wire logic fast_enable_in,
  // Oscillator levels: slow RC, slow crystal, fast RC, fast crystal.
  output logic      slow_rc_out,
  output logic      slow_xt_out,
  output logic      fast_rc_out,
  output logic      fast_xt_out
);
  // Half periods in clock cycles; each level stays at least two cycles.
  localparam int HALF [4] = '{3, 4, 2, 5};
  int         cnt [4] = '{default: 0};
  logic [3:0] lvl = 4'h0;
  logic [3:0] run;

  assign run = {fast_enable_in, fast_enable_in, slow_enable_in, slow_enable_in};
  assign {fast_xt_out, fast_rc_out, slow_xt_out, slow_rc_out} = lvl;

  // A disabled oscillator freezes, as a stopped crystal does.
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 4; i++) begin
      if (run[i]) begin
        cnt[i] <= (cnt[i] == HALF[i] - 1) ? 0 : cnt[i] + 1;
        if (cnt[i] == HALF[i] - 1) begin
          lvl[i] <= ~lvl[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/scc_top_properties.sv
// Concurrent checks on the controller's bus and clock outputs.
`timescale 1ns/1ps
`default_nettype none
module scc_top_properties
  import scc_pkg::*;
(
  // Watched ports of the controller.
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        stop_mode_in,
  input wire logic        slow_osc_enable_out,
  input wire logic        fast_crystal_select_out,
  input wire logic        crystal_high_gain_out,
  input wire logic        crystal_pins_claim_out,
  input wire logic        transient_detector1_enable_out,
  input wire logic        transient_detector2_enable_out,
  input wire logic [1:0]  transient_detector1_sensitivity_out,
  input wire logic        system_tick_out,
  input wire logic        peripheral_tick_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  logic       take_trans;  // A write to the detector register is taken.
  logic [7:0] trans_q;     // Last byte written to the detector register.

  assign take_trans = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                      && (wb_adr_in[11:2] == SCC_TRANSIENT_INDEX);

  // Keeps the written byte so the outputs can be compared later.
  always_ff @(posedge clock_in) begin
    if (take_trans) begin
      trans_q <= wb_dat_in[7:0];
    end
  end

  chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acknowledged next cycle");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge longer than one cycle");
  chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("acknowledge without request");
  chk_read_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_gain_claim: assert property (fast_crystal_select_out |-> crystal_high_gain_out && crystal_pins_claim_out)
    else $error("fast crystal without high gain or pin claim");
  chk_slow_halt: assert property (!slow_osc_enable_out |-> $past(stop_mode_in))
    else $error("slow oscillator halted outside stop mode");
  chk_periph_pulse: assert property (peripheral_tick_out |-> system_tick_out)
    else $error("peripheral tick without system tick");
  chk_tick_single: assert property (system_tick_out |=> !system_tick_out)
    else $error("system tick longer than one cycle");
  chk_trans_fields: assert property (take_trans |=> ##1 ({transient_detector2_enable_out, transient_detector1_enable_out, transient_detector1_sensitivity_out} == trans_q[7:4]))
    else $error("detector outputs differ from written byte");
endmodule
bind scc_top scc_top_properties u_chk (.*);
`default_nettype wire

// ### test/system_clock_source_control_tb.sv
// Self-checking bench for the system clock source controller.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_tb;
  import scc_pkg::*;
  typedef struct {logic wr; logic [9:0] idx; logic [3:0] sel; logic [7:0] wd; logic [7:0] rd;} scc_row_type;
  localparam logic [9:0] CC = SCC_CLOCK_CONTROL_INDEX;
  localparam logic [9:0] TR = SCC_TRANSIENT_INDEX;
  localparam int DIVS [4] = '{16, 4, 2, 1};
  logic        clock_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [11:0] wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic        slow_rc_osc_in, slow_crystal_in, fast_rc_osc_in, fast_crystal_in;
  logic        transient_detector1_in, transient_detector2_in, stop_mode_in, idle_mode_in;
  logic        slow_osc_enable_out, fast_osc_enable_out, slow_crystal_select_out;
  logic        fast_crystal_select_out, crystal_high_gain_out, crystal_pins_claim_out;
  logic        transient_detector1_enable_out, transient_detector2_enable_out;
  logic [1:0]  transient_detector1_sensitivity_out;
  logic        transient_cpu_wait_out, system_tick_out, peripheral_tick_out;
  logic [7:0]  rd;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          ns, np;
  // Accesses with their expected read-back; protected bits keep old values.
  scc_row_type rows [12] = '{
    '{0, CC, 4'h1, 8'h00, 8'h23}, '{0, TR, 4'h1, 8'h00, 8'h00},
    '{1, TR, 4'h1, 8'hff, 8'hfc}, '{1, TR, 4'h0, 8'h00, 8'hfc},
    '{1, TR, 4'h1, 8'h00, 8'h00}, '{1, 10'h3ff, 4'h1, 8'h55, 8'h00},
    '{1, CC, 4'h1, 8'h47, 8'h47}, '{1, CC, 4'h1, 8'hcf, 8'hc7},
    '{1, CC, 4'h1, 8'h0b, 8'h43}, '{1, CC, 4'h1, 8'h0b, 8'h0b},
    '{1, CC, 4'h1, 8'h0f, 8'h0b}, '{1, CC, 4'h1, 8'h03, 8'h03}};

  scc_top dut (.*);
  scc_osc_model u_osc (.clock_in(clock_in), .slow_enable_in(slow_osc_enable_out),
    .fast_enable_in(fast_osc_enable_out), .slow_rc_out(slow_rc_osc_in),
    .slow_xt_out(slow_crystal_in), .fast_rc_out(fast_rc_osc_in), .fast_xt_out(fast_crystal_in));

  // Free-running 10 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, entered right after a rising edge.
  task automatic bus(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                     input logic [7:0] wd, output logic [7:0] q);
    int n;
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, we};
    wb_adr_in <= {idx, 2'h0};
    wb_sel_in <= sel;
    wb_dat_in <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    q = wb_dat_out[7:0];
    {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'h0;
    @(posedge clock_in);
    if (n >= 20) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Measures the cycles between two system ticks; the waits are bounded.
  task automatic gap(input int exp);
    int a;
    int t;
    t = 0;
    while (system_tick_out !== 1'b1 && t < 400) begin
      @(posedge clock_in);
      t++;
    end
    @(posedge clock_in);
    a = 1;
    while (system_tick_out !== 1'b1 && a < 400) begin
      @(posedge clock_in);
      a++;
    end
    if (t >= 400 || a >= 400) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      check(a, exp);
    end
  endtask

  // Counts system and peripheral ticks over sixty cycles.
  task automatic count();
    ns = 0;
    np = 0;
    repeat (60) begin
      @(posedge clock_in);
      ns += int'(system_tick_out === 1'b1);
      np += int'(peripheral_tick_out === 1'b1);
    end
  endtask

  // Main sequence: table first, then the hand-written cases.
  initial begin
    {wb_cyc_in, wb_stb_in, wb_we_in, stop_mode_in, idle_mode_in} = 5'h0;
    {transient_detector1_in, transient_detector2_in} = 2'h0;
    wb_adr_in = 12'h0;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    sys_rst_in = 1'b1;
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        bus(1'b1, rows[i].idx, rows[i].sel, rows[i].wd, rd);
      end
      bus(1'b0, rows[i].idx, 4'h1, 8'h00, rd);
      check(rd, rows[i].rd);
    end
    $display("test register table done");
    for (int c = 3; c >= 0; c--) begin
      bus(1'b1, CC, 4'h1, {6'h0, c[1:0]}, rd);
      repeat (110) @(posedge clock_in);
      gap(6 * DIVS[c]);
    end
    $display("test divider done");
    bus(1'b1, CC, 4'h1, 8'h07, rd);
    repeat (110) @(posedge clock_in);
    gap(4);
    bus(1'b1, TR, 4'h1, 8'hcc, rd);
    transient_detector1_in <= 1'b1;
    repeat (30) @(posedge clock_in);
    check(transient_cpu_wait_out, 1);
    gap(6);
    transient_detector1_in <= 1'b0;
    repeat (30) @(posedge clock_in);
    check(transient_cpu_wait_out, 0);
    gap(4);
    transient_detector2_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    check(transient_cpu_wait_out, 1);
    transient_detector2_in <= 1'b0;
    bus(1'b1, TR, 4'h1, 8'h00, rd);
    $display("test transient done");
    bus(1'b1, CC, 4'h1, 8'h97, rd);
    check({slow_crystal_select_out, crystal_pins_claim_out,
           crystal_high_gain_out}, 6);
    idle_mode_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    count();
    check({np[30:0], ns > 0}, 32'h1);
    bus(1'b1, CC, 4'h1, 8'h07, rd);
    repeat (5) @(posedge clock_in);
    count();
    check(np, ns);
    idle_mode_in <= 1'b0;
    $display("test idle gate done");
    bus(1'b1, CC, 4'h1, 8'h03, rd);
    repeat (20) @(posedge clock_in);
    bus(1'b1, CC, 4'h1, 8'h4b, rd);
    repeat (3) @(posedge clock_in);
    check({fast_osc_enable_out, crystal_high_gain_out, crystal_pins_claim_out,
           fast_crystal_select_out}, 7);
    stop_mode_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check(slow_osc_enable_out, 1);
    bus(1'b1, CC, 4'h1, 8'h6b, rd);
    repeat (3) @(posedge clock_in);
    check(slow_osc_enable_out, 0);
    stop_mode_in <= 1'b0;
    $display("test stop done");
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    check({slow_osc_enable_out, fast_osc_enable_out, crystal_pins_claim_out}, 6);
    bus(1'b0, CC, 4'h1, 8'h00, rd);
    check(rd, 8'h23);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
